// ===== rtl/rbml_loader.sv
// Boot-mode loader: decodes the rotary switches once after power-on,
// copies flash to SRAM in ROM mode, clears SRAM in clear mode, and
// commits SRAM to flash on request in RAM mode.
// Assumes switch inputs synchronous to mclk and stable while powered.
//
// Contract
// RULE_01: First switch A, second not C, selects installation mode.
// RULE_02: Both switches 0 selects RAM mode, running from SRAM.
// RULE_03: First switch 0 and second 6 selects ROM mode.
// RULE_04: Second switch C clears programs, parameters, positions, latches.
// RULE_05: Mode decoded only at power-on, held until next power-on.
// RULE_06: Operator never changes switches while powered.
// RULE_07: Operator uses only the listed switch combinations.
// RULE_08: RAM mode blinks decimal point of the first digit.
// RULE_09: ROM mode blinks first point, second point steady on.
// RULE_10: RAM mode accepts requests to copy SRAM into flash.
// RULE_11: ROM mode copies flash to SRAM at reset, then runs.
// RULE_12: ROM mode discards uncommitted SRAM edits on next reset.
// RULE_13: Flash write erases whole flash, then batch-copies SRAM.
// RULE_14: Image holds programs and settings, not positions or latches.
// RULE_15: Flash write only with ready flag off, not installation mode.
// RULE_16: Flash worn after 100000 writes; further writes report error.
// RULE_17: ROM-mode online changes run now but are not stored.
// RULE_18: Host backup and restore touch SRAM only, never flash.
// RULE_19: Host loads complete SRAM contents before requesting write.
// RULE_20: Refused write flags error and changes neither flash nor SRAM.
`timescale 1ns/10ps
module rbml_loader #(
  parameter int AW = 8, // Word address width of each store.
  parameter int BLINK_HALF = rbml_pkg::BLINK_CYCLES, // Blink half-period.
  parameter logic [31:0] LIFE = rbml_pkg::FLASH_LIFE, // Flash write life.
  parameter logic EXTENDED = 1'b0 // Extended variant; adds regions 5 and 6 to the region mask readback only, not to the image.
) (
  input wire logic mclk, // 40 MHz clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic power_on, // High for the first reset after power-up.
  input wire logic [3:0] mode_switch_one, // First rotary switch.
  input wire logic [3:0] mode_switch_two, // Second rotary switch.
  input wire logic [7:0] avs_address, // Avalon byte address.
  input wire logic avs_read, // Avalon read.
  input wire logic avs_write, // Avalon write.
  input wire logic [31:0] avs_writedata, // Avalon write data.
  output logic [31:0] avs_readdata, // Avalon read data.
  output logic avs_waitrequest, // Avalon wait request.
  output logic dp_first, // First digit decimal point.
  output logic dp_second, // Second digit decimal point.
  output logic run_ok // Normal operation may proceed.
);

  typedef enum logic [2:0] {
    RBML_ST_IDLE, RBML_ST_CLEAR, RBML_ST_LOAD, RBML_ST_ERASE,
    RBML_ST_COPY, RBML_ST_RUN
  } rbml_state_t;

  localparam logic [AW-1:0] LAST = {AW{1'b1}};

  rbml_state_t st_q, st_d;
  rbml_pkg::rbml_mode_t mode_q;
  logic captured_q;
  logic [AW-1:0] idx_q;
  logic [AW-1:0] host_addr_q;
  logic ready_flag_q;
  logic reject_q, wear_q, done_q;
  logic [31:0] wcount_q;
  logic rd_pend_q;
  logic first_q;
  logic ack_q;
  logic blink;
  logic [31:0] sram_rdata, flash_rdata;

  // Region of a word is its top three address bits.
  function automatic logic in_image(input logic [AW-1:0] a,
                                    input logic ext);
    logic [7:0] m;
    m = rbml_pkg::IMAGE_REGIONS | (ext ? rbml_pkg::EXT_REGIONS : 8'h00);
    m[5] = 1'b0;
    m[6] = 1'b0;
    m[7] = 1'b0;
    return m[a[AW-1 -: 3]];
  endfunction : in_image

  // Switch decoding: clear wins over installation, as the table says.
  wire sw_clear = mode_switch_two == rbml_pkg::SW_CODE_CLEAR; // [RULE_04]
  wire sw_install = mode_switch_one == rbml_pkg::SW_CODE_INSTALL
                    && !sw_clear; // [RULE_01]
  wire sw_ram = mode_switch_one == rbml_pkg::SW_CODE_ZERO
                && mode_switch_two == rbml_pkg::SW_CODE_ZERO; // [RULE_02]
  wire sw_rom = mode_switch_one == rbml_pkg::SW_CODE_ZERO
                && mode_switch_two == rbml_pkg::SW_CODE_SIX; // [RULE_03]
  wire rbml_pkg::rbml_mode_t sw_mode =
    sw_clear ? rbml_pkg::RBML_MODE_CLEAR :
    sw_install ? rbml_pkg::RBML_MODE_INSTALL :
    sw_ram ? rbml_pkg::RBML_MODE_RAM :
    sw_rom ? rbml_pkg::RBML_MODE_ROM : rbml_pkg::RBML_MODE_ILLEGAL;

  // Bus decode.
  wire bus_req = (avs_read || avs_write) && !ack_q;
  wire wr_ctl = avs_write && !ack_q
                && avs_address == rbml_pkg::REG_CONTROL;
  wire wr_data = avs_write && !ack_q
                 && avs_address == rbml_pkg::REG_HOST_DATA;
  wire rd_data = avs_read && !ack_q
                 && avs_address == rbml_pkg::REG_HOST_DATA;
  wire flash_req = wr_ctl && avs_writedata[rbml_pkg::CTL_FLASH_WRITE];
  wire busy = st_q != RBML_ST_RUN;
  wire write_ok = st_q == RBML_ST_RUN && !ready_flag_q
                  && mode_q != rbml_pkg::RBML_MODE_INSTALL
                  && mode_q != rbml_pkg::RBML_MODE_ILLEGAL; // [RULE_15]
  wire worn = wcount_q >= LIFE; // [RULE_16]
  wire go_flash = flash_req && write_ok && !worn; // [RULE_10]
  wire refuse = flash_req && !(write_ok && !worn); // [RULE_20]
  wire idx_last = idx_q == LAST;

  // Sequencer after reset and during a flash write.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      RBML_ST_IDLE: begin
        if (mode_q == rbml_pkg::RBML_MODE_CLEAR) begin
          st_d = RBML_ST_CLEAR;
        end else if (mode_q == rbml_pkg::RBML_MODE_ROM) begin
          st_d = RBML_ST_LOAD; // [RULE_11] [RULE_12] [RULE_17]
        end else begin
          st_d = RBML_ST_RUN;
        end
      end
      RBML_ST_CLEAR: if (idx_last) st_d = RBML_ST_RUN;
      RBML_ST_LOAD: if (idx_last) st_d = RBML_ST_RUN;
      RBML_ST_ERASE: if (idx_last) st_d = RBML_ST_COPY; // [RULE_13]
      RBML_ST_COPY: if (idx_last) st_d = RBML_ST_RUN;
      RBML_ST_RUN: if (go_flash) st_d = RBML_ST_ERASE;
    endcase
  end

  // The store read lags the address by one cycle, so load and copy
  // write the word at idx_q - 1. The last word always lies in region 7,
  // which the image never holds, so no flush step is needed.
  wire [AW-1:0] prev_idx = idx_q - {{(AW-1){1'b0}}, 1'b1};
  wire load_we = st_q == RBML_ST_LOAD && !first_q
                 && in_image(prev_idx, EXTENDED);
  wire copy_we = st_q == RBML_ST_COPY && !first_q
                 && in_image(prev_idx, EXTENDED); // [RULE_14]
  wire clear_we = st_q == RBML_ST_CLEAR; // [RULE_04]
  wire erase_we = st_q == RBML_ST_ERASE;
  wire host_we = wr_data && st_q == RBML_ST_RUN; // [RULE_18]

  wire sram_we = load_we || clear_we || host_we;
  wire [AW-1:0] sram_addr = load_we ? prev_idx :
                            clear_we ? idx_q :
                            st_q == RBML_ST_RUN ? host_addr_q : idx_q;
  wire [31:0] sram_wdata = load_we ? flash_rdata :
                           host_we ? avs_writedata : 32'h00000000;
  wire flash_we = erase_we || copy_we;
  wire [AW-1:0] flash_addr = copy_we ? prev_idx : idx_q;
  wire [31:0] flash_wdata = copy_we ? sram_rdata : 32'hFFFFFFFF;

  // Sequencing states walk every word of the store exactly once.
  wire seq_active = st_q == RBML_ST_CLEAR || st_q == RBML_ST_LOAD
                    || st_q == RBML_ST_ERASE || st_q == RBML_ST_COPY;

  // Read mux.
  wire [31:0] status_word = {23'h000000, done_q, wear_q, reject_q,
                             !busy, busy, 1'b0, mode_q};
  wire [31:0] rd_mux =
    avs_address == rbml_pkg::REG_STATUS ? status_word :
    avs_address == rbml_pkg::REG_CONTROL ?
      {30'h00000000, ready_flag_q, 1'b0} :
    avs_address == rbml_pkg::REG_WRITE_COUNT ? wcount_q :
    avs_address == rbml_pkg::REG_HOST_ADDR ?
      {{(32-AW){1'b0}}, host_addr_q} :
    avs_address == rbml_pkg::REG_REGION_MASK ?
      {24'h000000, rbml_pkg::IMAGE_REGIONS
       | (EXTENDED ? rbml_pkg::EXT_REGIONS : 8'h00)} :
    32'h00000000;

  rbml_mem #(.AW(AW), .DW(32)) u_sram (
    .clk(mclk), .we(sram_we), .addr(sram_addr),
    .wdata(sram_wdata), .rdata(sram_rdata));

  rbml_mem #(.AW(AW), .DW(32)) u_flash (
    .clk(mclk), .we(flash_we), .addr(flash_addr),
    .wdata(flash_wdata), .rdata(flash_rdata));

  rbml_blink #(.HALF(BLINK_HALF)) u_blink (
    .mclk(mclk), .nrst(nrst), .blink(blink));

  // Mode capture: latched once on the first clock after a power-on reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      captured_q <= 1'b0;
    end else begin
      captured_q <= 1'b1;
    end
  end

  // Mode register survives system reset; only power-on reloads it.
  always_ff @(posedge mclk) begin
    if (!captured_q && power_on) begin
      mode_q <= sw_mode; // [RULE_05]
    end
  end

  // State and index.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RBML_ST_IDLE;
      idx_q <= '0;
      first_q <= 1'b1;
    end else if (!captured_q) begin
      st_q <= RBML_ST_IDLE;
    end else begin
      st_q <= st_d;
      idx_q <= seq_active ? idx_q + {{(AW-1){1'b0}}, 1'b1} : '0;
      first_q <= !seq_active || (idx_last && !first_q);
    end
  end

  // Control and status flags; a new refusal wins over a clear.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ready_flag_q <= 1'b0;
      reject_q <= 1'b0;
      wear_q <= 1'b0;
      done_q <= 1'b0;
      host_addr_q <= '0;
    end else begin
      if (wr_ctl) begin
        ready_flag_q <= avs_writedata[rbml_pkg::CTL_READY_FLAG];
      end
      if (avs_write && !ack_q
          && avs_address == rbml_pkg::REG_HOST_ADDR) begin
        host_addr_q <= avs_writedata[AW-1:0];
      end
      if (refuse) begin
        reject_q <= 1'b1; // [RULE_20]
        wear_q <= wear_q | (write_ok && worn); // [RULE_16]
      end else if (wr_ctl && avs_writedata[rbml_pkg::CTL_CLEAR_ERR]) begin
        reject_q <= 1'b0;
        wear_q <= 1'b0;
      end
      if (st_q == RBML_ST_COPY && st_d == RBML_ST_RUN) begin
        done_q <= 1'b1;
      end else if (go_flash) begin
        done_q <= 1'b0;
      end
    end
  end

  // Flash write counter; kept across system reset like the flash itself.
  always_ff @(posedge mclk) begin
    if (!captured_q && power_on && !nrst) begin
      wcount_q <= rbml_pkg::WRITE_COUNT_RST;
    end else if (go_flash) begin
      wcount_q <= wcount_q + 32'h00000001; // [RULE_16]
    end
  end

  // Bus slave: one wait cycle, reads of memory data need a second.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rd_pend_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      rd_pend_q <= rd_data && !rd_pend_q;
      ack_q <= bus_req && !(rd_data && !rd_pend_q);
      avs_waitrequest <= !(bus_req && !(rd_data && !rd_pend_q));
      avs_readdata <= rd_data ? (busy ? 32'h00000000 : sram_rdata)
                              : rd_mux;
    end
  end

  // Display and run indication.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dp_first <= 1'b0;
      dp_second <= 1'b0;
      run_ok <= 1'b0;
    end else begin
      dp_first <= (mode_q == rbml_pkg::RBML_MODE_RAM
                   || mode_q == rbml_pkg::RBML_MODE_ROM)
                  && blink; // [RULE_08] [RULE_09]
      dp_second <= mode_q == rbml_pkg::RBML_MODE_ROM; // [RULE_09]
      run_ok <= st_q == RBML_ST_RUN; // [RULE_11]
    end
  end

  // Checks on what this block drives; an erase already running may go on.
  chk_rom_no_run: assert property ( // [RULE_11]
    @(posedge mclk) disable iff (!nrst)
    st_q == RBML_ST_LOAD |=> !run_ok)
    else $error("run started during flash load");
  chk_erase_then_copy: assert property ( // [RULE_13]
    @(posedge mclk) disable iff (!nrst)
    st_q == RBML_ST_COPY && $past(st_q) != RBML_ST_COPY
    |-> $past(st_q) == RBML_ST_ERASE && $past(idx_q) == LAST)
    else $error("copy began before a full erase");
  chk_refuse_no_write: assert property ( // [RULE_20]
    @(posedge mclk) disable iff (!nrst)
    refuse |=> reject_q && $stable(wcount_q)
    && (st_q != RBML_ST_ERASE || $past(st_q) == RBML_ST_ERASE))
    else $error("refused write changed state");
  chk_ready_blocks: assert property ( // [RULE_15]
    @(posedge mclk) disable iff (!nrst)
    flash_req && ready_flag_q
    |=> st_q != RBML_ST_ERASE || $past(st_q) == RBML_ST_ERASE)
    else $error("write with ready flag on");
  chk_mode_held: assert property ( // [RULE_05]
    @(posedge mclk) disable iff (!nrst)
    captured_q |=> $stable(mode_q))
    else $error("mode changed while running");
  chk_rom_dot: assert property ( // [RULE_09]
    @(posedge mclk) disable iff (!nrst)
    mode_q == rbml_pkg::RBML_MODE_ROM |=> dp_second)
    else $error("second dot off in ROM mode");
  chk_ram_dot: assert property ( // [RULE_08]
    @(posedge mclk) disable iff (!nrst)
    mode_q == rbml_pkg::RBML_MODE_RAM |=> !dp_second)
    else $error("second dot lit in RAM mode");
  chk_wear_limit: assert property ( // [RULE_16]
    @(posedge mclk) disable iff (!nrst)
    flash_req && worn
    |=> st_q != RBML_ST_ERASE || $past(st_q) == RBML_ST_ERASE)
    else $error("write past flash life");
  chk_host_sram: assert property ( // [RULE_18]
    @(posedge mclk) disable iff (!nrst)
    st_q == RBML_ST_RUN |-> !flash_we)
    else $error("flash written outside commit");
  chk_dot_off: assert property ( // [RULE_08]
    @(posedge mclk) disable iff (!nrst)
    mode_q != rbml_pkg::RBML_MODE_RAM && mode_q != rbml_pkg::RBML_MODE_ROM
    |=> !dp_first)
    else $error("first dot lit outside RAM and ROM modes");
  chk_copy_image: assert property ( // [RULE_14]
    @(posedge mclk) disable iff (!nrst)
    copy_we |-> flash_addr[AW-1 -: 3] < 3'h5)
    else $error("position or latch word copied to flash");
  chk_load_image: assert property ( // [RULE_11]
    @(posedge mclk) disable iff (!nrst)
    load_we |-> sram_addr[AW-1 -: 3] < 3'h5 && sram_wdata == flash_rdata)
    else $error("load touched a word outside the image");
  chk_rom_loads: assert property ( // [RULE_11]
    @(posedge mclk) disable iff (!nrst)
    st_q == RBML_ST_RUN && $past(st_q) == RBML_ST_IDLE
    |-> mode_q != rbml_pkg::RBML_MODE_ROM
    && mode_q != rbml_pkg::RBML_MODE_CLEAR)
    else $error("ROM or clear mode ran without its start-up pass");
  chk_clear_zero: assert property ( // [RULE_04]
    @(posedge mclk) disable iff (!nrst)
    st_q == RBML_ST_CLEAR |-> sram_we && sram_addr == idx_q
    && sram_wdata == 32'h00000000)
    else $error("clear pass skipped a word");

endmodule : rbml_loader

// ===== rtl/rbml_pkg.sv
// Shared constants for the boot-mode loader: mode codes, switch codes,
// register map, field positions, reset values and timing counts.
// Assumes a single 40 MHz clock domain and an Avalon-MM register slave.
package rbml_pkg;

  // Operating modes decoded from the rotary switches.
  typedef enum logic [2:0] {
    RBML_MODE_INSTALL,
    RBML_MODE_RAM,
    RBML_MODE_ROM,
    RBML_MODE_CLEAR,
    RBML_MODE_ILLEGAL
  } rbml_mode_t;

  // Switch positions that select a mode.
  localparam logic [3:0] SW_CODE_ZERO = 4'h0;
  localparam logic [3:0] SW_CODE_SIX = 4'h6;
  localparam logic [3:0] SW_CODE_INSTALL = 4'hA;
  localparam logic [3:0] SW_CODE_CLEAR = 4'hC;

  // Register word offsets (byte addresses).
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_WRITE_COUNT = 8'h08;
  localparam logic [7:0] REG_HOST_ADDR = 8'h0C;
  localparam logic [7:0] REG_HOST_DATA = 8'h10;
  localparam logic [7:0] REG_REGION_MASK = 8'h14;

  // Control register bit positions.
  localparam int CTL_FLASH_WRITE = 0;
  localparam int CTL_READY_FLAG = 1;
  localparam int CTL_CLEAR_ERR = 2;

  // Status register bit positions.
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BUSY = 4;
  localparam int ST_RUN = 5;
  localparam int ST_REJECT = 6;
  localparam int ST_WEAR_ERR = 7;
  localparam int ST_DONE = 8;

  // Flash life in write cycles.
  localparam logic [31:0] FLASH_LIFE = 32'h000186A0;

  // Region masks; the flash image keeps regions 0 to 4, while absolute position,
  // home position and latch data live in regions 5, 6 and 7.
  localparam logic [7:0] IMAGE_REGIONS = 8'h1F;
  localparam logic [7:0] EXT_REGIONS = 8'h60;

  // Blink half-period of the first-digit decimal point.
  localparam int BLINK_MS = 250;
  localparam int CLK_KHZ = 40000;
  localparam int BLINK_CYCLES = BLINK_MS * CLK_KHZ;

  // Reset values.
  localparam logic [31:0] WRITE_COUNT_RST = 32'h00000000;

endpackage : rbml_pkg

// ===== rtl/rbml_mem.sv
// Single-port word memory with registered read data.
// Used for both the SRAM image and the flash store; one access per clock.
`timescale 1ns/10ps
module rbml_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input wire logic clk, // Clock.
  input wire logic we, // Write strobe.
  input wire logic [AW-1:0] addr, // Word address.
  input wire logic [DW-1:0] wdata, // Write data.
  output logic [DW-1:0] rdata // Registered read data.
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write on strobe; read data always registered.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : rbml_mem

// ===== rtl/rbml_blink.sv
// Free-running blink generator for the display decimal point.
// Assumes a synchronous clock; toggles every HALF cycles after reset.
`timescale 1ns/10ps
module rbml_blink #(
  parameter int HALF = rbml_pkg::BLINK_CYCLES
) (
  input wire logic mclk, // Clock.
  input wire logic nrst, // Asynchronous reset, active low.
  output logic blink // Square wave.
);

  logic [31:0] cnt_q;

  // Counts one half-period, then flips the output.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 32'h00000000;
      blink <= 1'b0;
    end else if (cnt_q >= 32'(HALF - 1)) begin
      cnt_q <= 32'h00000000;
      blink <= ~blink;
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
    end
  end

endmodule : rbml_blink

// ===== bench/rbml_host.sv
// Model of the host engineering tool as an Avalon-MM master.
// Assumes one mclk domain; the bench calls wr and rd just after an edge.
`timescale 1ns/10ps
module rbml_host (
  input wire logic mclk, // Bus clock.
  output logic [7:0] avs_address, // Byte address.
  output logic avs_read, // Read request.
  output logic avs_write, // Write request.
  output logic [31:0] avs_writedata, // Write data.
  input wire logic [31:0] avs_readdata, // Read data.
  input wire logic avs_waitrequest // Slave not ready.
);
  // Idle bus from time zero; address and data toggle when idle.
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end

  // Holds the write until waitrequest is seen low, then lets an edge pass.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
    @(posedge mclk);
  endtask : wr

  // Holds the read until waitrequest is low and takes data at that edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_address <= ~a;
    @(posedge mclk);
  endtask : rd
endmodule : rbml_host

// ===== bench/rbml_loader_tb_top.sv
// Self-checking bench for the boot-mode loader with a host bus model.
// Assumes small stores (AW 4), a short blink and a flash life of 3.
`timescale 1ns/10ps
module rbml_loader_tb_top;
  localparam int AW = 4;
  logic mclk, nrst, power_on, avs_read, avs_write;
  logic [3:0] sw_one, sw_two;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, st, v;
  logic [31:0] img [16];
  logic avs_waitrequest, dp_first, dp_second, run_ok;
  int errors = 0;
  int checks = 0;
  int cyc = 0;

  rbml_loader #(.AW(AW), .BLINK_HALF(4), .LIFE(32'h00000003),
    .EXTENDED(1'b0)) dut (.mclk(mclk), .nrst(nrst), .power_on(power_on),
    .mode_switch_one(sw_one), .mode_switch_two(sw_two),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dp_first(dp_first), .dp_second(dp_second), .run_ok(run_ok));

  rbml_host host (.mclk(mclk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // Clock of 25 ns and a cycle ceiling that cuts a hang short.
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
  end

  // Mode expected from the two switch codes.
  function automatic logic [2:0] exp_mode(input logic [3:0] a, b);
    if (b == rbml_pkg::SW_CODE_CLEAR) return 3'h3;
    if (a == rbml_pkg::SW_CODE_INSTALL) return 3'h0;
    if (a == 4'h0 && b == 4'h0) return 3'h1;
    if (a == 4'h0 && b == rbml_pkg::SW_CODE_SIX) return 3'h2;
    return 3'h4;
  endfunction : exp_mode

  // True when a word belongs to a region kept in the flash image.
  function automatic logic in_image(input int w);
    return rbml_pkg::IMAGE_REGIONS[w >> (AW - 3)];
  endfunction : in_image

  task automatic check(input logic [31:0] seen, exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Reset with switches set while held; power_on marks a power-up.
  task automatic restart(input logic [3:0] a, b, input logic pwr);
    int n;
    nrst <= 1'b0;
    power_on <= pwr;
    sw_one <= a;
    sw_two <= b;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    n = 0;
    while (run_ok !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    check(run_ok, 1'b1, "start finished");
    power_on <= 1'b0;
    @(posedge mclk);
  endtask : restart

  task automatic sram_wr(input int w, input logic [31:0] d);
    host.wr(rbml_pkg::REG_HOST_ADDR, w);
    host.wr(rbml_pkg::REG_HOST_DATA, d);
  endtask : sram_wr

  task automatic sram_rd(input int w, output logic [31:0] d);
    host.wr(rbml_pkg::REG_HOST_ADDR, w);
    host.rd(rbml_pkg::REG_HOST_DATA, d);
  endtask : sram_rd

  // Requests a flash write and polls until busy has gone.
  task automatic commit(input logic [31:0] ctl);
    int n;
    host.wr(rbml_pkg::REG_CONTROL, ctl);
    n = 0;
    do begin
      host.rd(rbml_pkg::REG_STATUS, st);
      n++;
    end while (st[rbml_pkg::ST_BUSY] !== 1'b0 && n < 100);
    check(st[rbml_pkg::ST_BUSY], 1'b0, "busy ended");
  endtask : commit

  // Counts decimal point toggles over a stretch of cycles.
  task automatic blink_chk(input logic on);
    int t;
    logic p;
    t = 0;
    p = dp_first;
    repeat (24) begin
      @(posedge mclk);
      if (dp_first !== p) t++;
      p = dp_first;
    end
    check({31'h0, t > 2}, {31'h0, on}, "blink");
  endtask : blink_chk

  // Main sequence.
  initial begin
    logic [3:0] ta [4];
    logic [3:0] tb [4];
    logic [2:0] m;
    nrst = 1'b0;
    power_on = 1'b1;
    sw_one = 4'h0;
    sw_two = 4'h0;
    void'($urandom(32'h8CFA));
    ta = '{4'hA, 4'h7, 4'h0, 4'h0};
    tb = '{4'h3, 4'hC, 4'h6, 4'h0};
    // One switch setting per documented mode, ending in RAM mode.
    for (int i = 0; i < 4; i++) begin
      restart(ta[i], tb[i], 1'b1);
      m = exp_mode(ta[i], tb[i]);
      host.rd(rbml_pkg::REG_STATUS, st);
      check(st[2:0], m, "mode");
      check(dp_second, m == 3'h2, "second point");
      blink_chk(m == 3'h1 || m == 3'h2);
    end
    $display("test modes done");
    // Whole image loaded first, then committed.
    for (int w = 0; w < 16; w++) begin
      img[w] = $urandom;
      sram_wr(w, img[w]);
    end
    commit(32'h1);
    check(st[rbml_pkg::ST_DONE], 1'b1, "done");
    host.rd(rbml_pkg::REG_WRITE_COUNT, v);
    check(v, 32'h1, "count");
    // Ready flag set: refused, nothing written.
    host.wr(rbml_pkg::REG_CONTROL, 32'h2);
    commit(32'h3);
    check(st[rbml_pkg::ST_REJECT], 1'b1, "reject");
    host.rd(rbml_pkg::REG_WRITE_COUNT, v);
    check(v, 32'h1, "count kept");
    sram_rd(5, v);
    check(v, img[5], "sram kept");
    host.wr(rbml_pkg::REG_CONTROL, 32'h4);
    host.rd(rbml_pkg::REG_STATUS, st);
    check(st[rbml_pkg::ST_REJECT], 1'b0, "err clear");
    host.rd(8'hFC, v);
    check(v, 32'h0, "unmapped");
    // Two more writes reach the life; the next one is refused.
    commit(32'h1);
    commit(32'h1);
    commit(32'h1);
    check(st[rbml_pkg::ST_WEAR_ERR], 1'b1, "wear");
    check(st[rbml_pkg::ST_REJECT], 1'b1, "wear reject");
    host.rd(rbml_pkg::REG_WRITE_COUNT, v);
    check(v, 32'h3, "count at life");
    $display("test commit done");
    // Host data writes reach the SRAM only; ROM start restores flash.
    sram_wr(3, ~img[3]);
    restart(4'h0, 4'h6, 1'b1);
    check(run_ok, 1'b1, "run after load");
    for (int w = 0; w < 16; w++) begin
      sram_rd(w, v);
      if (in_image(w)) check(v, img[w], "rom load");
      else check(v, img[w], "kept");
    end
    sram_wr(0, ~img[0]);
    sram_rd(0, v);
    check(v, ~img[0], "online edit");
    restart(4'h0, 4'h6, 1'b0);
    sram_rd(0, v);
    check(v, img[0], "edit dropped");
    host.rd(rbml_pkg::REG_STATUS, st);
    check(st[2:0], 3'h2, "mode held");
    $display("test rom done");
    // Installation mode refuses a flash write.
    restart(4'hA, 4'h3, 1'b1);
    commit(32'h1);
    check(st[rbml_pkg::ST_REJECT], 1'b1, "install reject");
    // Clear mode empties the SRAM, image and excluded regions alike.
    restart(4'h7, 4'hC, 1'b1);
    for (int w = 0; w < 16; w++) begin
      sram_rd(w, v);
      check(v, 32'h0, "cleared");
    end
    $display("test clear done");
    report_and_stop();
  end
endmodule : rbml_loader_tb_top
